// ### psr_regulator.sv
// PID speed regulator: register port, input scheme, loop and flags
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module psr_regulator
    import psr_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Analog samples in 0.01 % units
    input wire logic [DW-1:0] ain1,
    input wire logic [DW-1:0] ain2,
    input wire logic [DW-1:0] ain4,
    // Contact inputs
    input wire logic pid_cancel_input,
    input wire logic speed_select_high,
    input wire logic speed_select_mid,
    input wire logic speed_select_low,
    input wire logic jog_input,
    input wire logic current_input_enable,
    input wire logic [1:0] run_state,
    // Drive outputs
    output logic [DW-1:0] speed_command,
    output logic [1:0] run_scheme,
    output logic ain4_enable,
    output logic upper_limit_flag,
    output logic lower_limit_flag,
    output logic forward_run_indicator
);
    localparam int SW = 3 * DW + 8;
    localparam int TW = $clog2(SAMPLE_CYC + 1);

    // Clamp a wide signed value onto the command range
    function automatic logic [15:0] sat_cmd(input logic signed [47:0] v);
        if (v < 0)
            return 16'h0000;
        if (v > 48'(FULL_SCALE))
            return FULL_SCALE;
        return v[15:0];
    endfunction : sat_cmd

    // Magnitude of a signed word
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for all pin inputs
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {ain1, ain2, ain4, pid_cancel_input, speed_select_high,
                       speed_select_mid, speed_select_low, jog_input,
                       current_input_enable, run_state};
            sync_q <= meta_q;
        end
    end

    wire signed [DW-1:0] ain1_s = sync_q[SW-1 -: DW];
    wire [DW-1:0] ain2_s = sync_q[2*DW+7 -: DW];
    wire [DW-1:0] ain4_s = sync_q[DW+7 -: DW];
    wire cancel_s = sync_q[7];
    wire multi_s = |sync_q[6:4];
    wire jog_s = sync_q[3];
    wire cur_en_s = sync_q[2];
    wire [1:0] run_s = sync_q[1:0];

    ////////////////////////////////////////////////////////////////////////
    // Settings registers
    logic [15:0] mode_q, band_q, ti_q, td_q, upper_q, lower_q, setpt_q, opm_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= RST_MODE;
            band_q <= RST_BAND;
            ti_q <= RST_TI;
            td_q <= RST_TD;
            upper_q <= RST_LIM;
            lower_q <= RST_LIM;
            setpt_q <= RST_SETPT;
            opm_q <= RST_OPM;
        end else if (reg_wr) begin
            case (reg_addr)
                ADR_MODE: mode_q <= reg_wdata;
                ADR_BAND: band_q <= reg_wdata;
                ADR_TI: ti_q <= reg_wdata;
                ADR_TD: td_q <= reg_wdata;
                ADR_UPPER: upper_q <= reg_wdata;
                ADR_LOWER: lower_q <= reg_wdata;
                ADR_SETPT: setpt_q <= reg_wdata;
                ADR_OPMODE: opm_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scheme and mode decode
    wire dev_sel = mode_q == MODE_DEV_REV || mode_q == MODE_DEV_FWD;
    wire spv_sel = mode_q == MODE_SPV_REV || mode_q == MODE_SPV_FWD;
    wire pid_sel = dev_sel || spv_sel;  // see [R1] see [R2]
    wire rev_sel = mode_q == MODE_DEV_REV || mode_q == MODE_SPV_REV;
    wire band_on = band_q != OFF_CODE && band_q != 16'h0000;  // see [R5]
    wire ti_on = ti_q != OFF_CODE && ti_q != 16'h0000;  // see [R6]
    wire td_on = td_q != OFF_CODE;  // see [R7]
    wire panel_sp = opm_q == OPM_PANEL || opm_q == OPM_COMB_A ||
                    opm_q == OPM_COMB_B;  // see [R10]
    wire pid_block = !pid_sel || opm_q == OPM_SWITCH || cancel_s;
    wire [1:0] scheme_d = jog_s ? SCH_JOG :
                          multi_s ? SCH_MULTI :  // see [R15]
                          pid_block ? SCH_NORMAL : SCH_PID;  // see [R14] see [R16]
    wire pid_run = run_scheme == SCH_PID;

    ////////////////////////////////////////////////////////////////////////
    // Deviation: set point plus input 1 minus input 4, or input 1 alone
    wire signed [18:0] sp_sum = $signed({3'b000, panel_sp ? setpt_q : ain2_s})
                                + 19'(ain1_s);  // see [R11] see [R12]
    wire signed [18:0] dev_raw = spv_sel ? sp_sum - $signed({3'b000, ain4_s})
                                         : 19'(ain1_s);  // see [R13]
    wire signed [18:0] err = rev_sel ? dev_raw : -dev_raw;  // see [R3] see [R4]
    wire [15:0] normal_cmd = sat_cmd(48'(sp_sum));

    ////////////////////////////////////////////////////////////////////////
    // Sample tick
    logic [TW-1:0] tick_q;
    wire tick = tick_q == TW'(SAMPLE_CYC - 1);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            tick_q <= '0;
        else
            tick_q <= tick ? '0 : tick_q + 1'b1;  // see [R21]
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop sequencer: P division, then I division, then sum
    psr_state_t st_q, st_d;
    logic div_busy;
    logic [31:0] quot;
    logic neg_q;
    logic signed [31:0] ge_q, gprev_q, acc_q;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (tick) st_d = ST_WAITP;
            ST_WAITP: if (!div_busy) st_d = ST_WAITI;
            ST_WAITI: if (!div_busy) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
        if (!pid_run)
            st_d = ST_IDLE;
    end

    // Scaled error and integral update
    wire [31:0] err_mag = mag(32'(err));
    wire signed [31:0] ge = neg_q ? -$signed(quot) : $signed(quot);
    wire signed [32:0] acc_sum = 33'(acc_q) + 33'(ge);
    wire signed [31:0] acc_nx = !ti_on ? 32'sd0 :
                                acc_sum > 33'(ACC_LIM) ? 32'(ACC_LIM) :
                                acc_sum < -33'(ACC_LIM) ? -32'(ACC_LIM) :
                                acc_sum[31:0];
    wire p_go = st_q == ST_IDLE && tick && pid_run;
    wire p_done = st_q == ST_WAITP && !div_busy && pid_run;
    wire i_done = st_q == ST_WAITI && !div_busy && pid_run;
    wire [31:0] div_dvd = p_go ? (band_on ? err_mag * BAND_NUM : err_mag)
                               : mag(acc_nx);  // see [R5]
    wire [31:0] div_dvs = p_go ? (band_on ? 32'(band_q) : 32'd1) :
                          ti_on ? 32'(ti_q) * 32'(TI_DIV) : 32'd1;  // see [R6]

    psr_div #(.W(32)) u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .start(p_go || p_done),
        .dividend(div_dvd),
        .divisor(div_dvs),
        .busy(div_busy),
        .quot(quot)
    );

    // Term sum: P on ge, I from accumulator, D on ge difference
    wire signed [31:0] i_term = !ti_on ? 32'sd0 :
                                acc_q[31] ? -$signed(quot) : $signed(quot);
    wire signed [47:0] d_term = !td_on ? 48'sd0 :
        48'(ge_q - gprev_q) * $signed({16'h0000, td_q}) *
        $signed({16'h0000, TD_MUL});  // see [R7]
    wire signed [47:0] mv = (band_on ? 48'(ge_q) : 48'sd0) + 48'(i_term)
                            + d_term;  // see [R20]

    // Loop state; cleared while PID is not running
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            neg_q <= 1'b0;
            ge_q <= '0;
            gprev_q <= '0;
            acc_q <= '0;
        end else begin
            st_q <= st_d;
            if (!pid_run) begin
                ge_q <= '0;
                gprev_q <= '0;  // see [R21]
                acc_q <= '0;
            end else if (p_go) begin
                neg_q <= err < 0;
            end else if (p_done) begin
                ge_q <= ge;
                acc_q <= acc_nx;
            end else if (i_done) begin
                gprev_q <= ge_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit flags, input 4 enable, indicator
    wire [19:0] pv20 = {4'h0, ain4_s};
    wire up_hit = pid_sel && upper_q != OFF_CODE &&
                  pv20 > 20'(upper_q) * 20'(LIM_MUL);  // see [R8]
    wire lo_hit = pid_sel && lower_q != OFF_CODE &&
                  pv20 < 20'(lower_q) * 20'(LIM_MUL);  // see [R9]
    wire [15:0] status = 16'({forward_run_indicator, pid_run,
                              lower_limit_flag, upper_limit_flag});
    wire [15:0] rd_mux = reg_addr == ADR_MODE ? mode_q :
                         reg_addr == ADR_BAND ? band_q :
                         reg_addr == ADR_TI ? ti_q :
                         reg_addr == ADR_TD ? td_q :
                         reg_addr == ADR_UPPER ? upper_q :
                         reg_addr == ADR_LOWER ? lower_q :
                         reg_addr == ADR_SETPT ? setpt_q :
                         reg_addr == ADR_OPMODE ? opm_q :
                         reg_addr == ADR_STATUS ? status :
                         reg_addr == ADR_CMD ? speed_command : 16'h0000;

    // Output registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_scheme <= SCH_NORMAL;
            speed_command <= 16'h0000;
            ain4_enable <= 1'b0;
            upper_limit_flag <= 1'b0;
            lower_limit_flag <= 1'b0;
            forward_run_indicator <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            run_scheme <= scheme_d;
            if (!pid_run)
                speed_command <= normal_cmd;  // see [R14]
            else if (i_done)
                speed_command <= sat_cmd(mv);  // see [R20]
            ain4_enable <= cur_en_s || pid_sel;  // see [R17]
            upper_limit_flag <= up_hit;
            lower_limit_flag <= lo_hit;
            forward_run_indicator <= run_s == RUN_FWD;  // see [R18]
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_mode_off_idle: assert property (
        mode_q == MODE_NONE && !jog_s && !multi_s |=> run_scheme == SCH_NORMAL
    ) else $error("PID ran with mode zero");  // see [R1]
    a_dev_rev_sign: assert property (
        mode_q == MODE_DEV_REV |-> err == 19'(ain1_s)
    ) else $error("Reverse deviation sign wrong");  // see [R3] see [R13]
    a_dev_fwd_sign: assert property (
        mode_q == MODE_DEV_FWD |-> err == -19'(ain1_s)
    ) else $error("Forward deviation sign wrong");  // see [R4]
    a_upper_flag_set: assert property (
        up_hit |=> upper_limit_flag ##0 $past(ain4_s) > 16'(upper_q)
    ) else $error("Upper flag missing");  // see [R8]
    a_upper_off_quiet: assert property (
        upper_q == OFF_CODE && $past(upper_q) == OFF_CODE |=> !upper_limit_flag
    ) else $error("Upper flag while off");  // see [R8]
    a_lower_off_quiet: assert property (
        lower_q == OFF_CODE |=> !lower_limit_flag
    ) else $error("Lower flag while off");  // see [R9]
    a_cancel_stops_pid: assert property (
        cancel_s && !jog_s && !multi_s |=> run_scheme == SCH_NORMAL
    ) else $error("Cancel did not stop PID");  // see [R14]
    a_jog_takes_over: assert property (
        jog_s |=> run_scheme == SCH_JOG
    ) else $error("Jog not selected");  // see [R15]
    a_switch_mode_no: assert property (
        opm_q == OPM_SWITCH |=> run_scheme != SCH_PID
    ) else $error("PID in switch-over mode");  // see [R16]
    a_ain4_auto_on: assert property (
        pid_sel |=> ain4_enable
    ) else $error("Input 4 not enabled");  // see [R17]
    a_fwd_indicator: assert property (
        ##1 forward_run_indicator == ($past(run_s) == RUN_FWD)
    ) else $error("Forward indicator wrong");  // see [R18]
    a_state_cleared: assert property (
        !pid_run |=> acc_q == 0 && gprev_q == 0 && st_q == ST_IDLE
    ) else $error("Loop state not cleared");  // see [R21]
    a_cmd_in_range: assert property (
        pid_run && i_done |=> speed_command <= FULL_SCALE
    ) else $error("Command out of range");  // see [R20]
    a_sample_bound: assert property (
        p_go |-> ##[1:70] st_q == ST_IDLE
    ) else $error("Sample not finished");  // see [R21]

    c_pid_update: cover property (pid_run && i_done);
    c_upper_rise: cover property (!upper_limit_flag ##1 upper_limit_flag);
    c_jog_from_pid: cover property (pid_run ##1 run_scheme == SCH_JOG);
endmodule : psr_regulator
`default_nettype wire

// ### psr_pkg.sv
// Constants for the PID speed regulator and its shared divider
//
// What this block does
// [R1] Mode 10/11 uses one deviation input, 10 reverse, 11 forward; 0 turns PID off.
// [R2] Mode 20/21 uses set point and process value, 20 reverse, 21 forward.
// [R3] Reverse action raises output for positive deviation, lowers it for negative.
// [R4] Forward action raises output for negative deviation, lowers it for positive.
// [R5] Proportional band 0.1 to 1000 %, smaller is stronger; 9999 removes it.
// [R6] Integral time 0.1 to 3600 s, shorter is faster; 9999 removes it.
// [R7] Derivative time 0.01 to 10 s, larger is stronger; 9999 removes it.
// [R8] Process value above upper limit raises upper flag; 9999 disables the check.
// [R9] Process value below lower limit raises lower flag; 9999 disables the check.
// [R10] Panel set point applies only in panel or combined operation modes.
// [R11] Modes 20/21 take set point from input 2, process value from input 4.
// [R12] In set point modes, input 1 is added to the input 2 set point.
// [R13] Modes 10/11 take deviation from input 1 and ignore inputs 2 and 4.
// [R14] While cancel input is high, PID stops and normal speed command runs.
// [R15] Any multi-speed or jog input stops PID and selects that operation.
// [R16] Operation mode 6 forbids PID regulation.
// [R17] Any PID mode enables input 4 without the current-input contact.
// [R18] Forward indicator is high only while run state shows forward.
// [R19] User calibrates process input end points to the set point speeds.
// [R20] Output is the sum of enabled P, I and D contributions.
// [R21] Fixed sample interval; I and D state clear whenever PID is not running.
package psr_pkg;
    localparam int DW = 16;
    // Register indices
    localparam logic [3:0] ADR_MODE = 4'h0;
    localparam logic [3:0] ADR_BAND = 4'h1;
    localparam logic [3:0] ADR_TI = 4'h2;
    localparam logic [3:0] ADR_TD = 4'h3;
    localparam logic [3:0] ADR_UPPER = 4'h4;
    localparam logic [3:0] ADR_LOWER = 4'h5;
    localparam logic [3:0] ADR_SETPT = 4'h6;
    localparam logic [3:0] ADR_OPMODE = 4'h7;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_CMD = 4'h9;
    // Status bit positions
    localparam int BIT_UP = 0;
    localparam int BIT_LO = 1;
    localparam int BIT_PID = 2;
    localparam int BIT_FWD = 3;
    // Setting codes
    localparam logic [15:0] OFF_CODE = 16'h270f;
    localparam logic [15:0] MODE_NONE = 16'h0000;
    localparam logic [15:0] MODE_DEV_REV = 16'h000a;
    localparam logic [15:0] MODE_DEV_FWD = 16'h000b;
    localparam logic [15:0] MODE_SPV_REV = 16'h0014;
    localparam logic [15:0] MODE_SPV_FWD = 16'h0015;
    localparam logic [15:0] OPM_PANEL = 16'h0001;
    localparam logic [15:0] OPM_COMB_A = 16'h0003;
    localparam logic [15:0] OPM_COMB_B = 16'h0004;
    localparam logic [15:0] OPM_SWITCH = 16'h0006;
    localparam logic [1:0] RUN_FWD = 2'h1;
    // Reset values
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [15:0] RST_BAND = 16'h03e8;
    localparam logic [15:0] RST_TI = 16'h000a;
    localparam logic [15:0] RST_TD = 16'h270f;
    localparam logic [15:0] RST_LIM = 16'h270f;
    localparam logic [15:0] RST_SETPT = 16'h0000;
    localparam logic [15:0] RST_OPM = 16'h0000;
    // Scaling: 10000 = 100.00 %, band in 0.1 %, limits in 0.1 %
    localparam logic [15:0] FULL_SCALE = 16'h2710;
    localparam logic [31:0] BAND_NUM = 32'h0000_03e8;
    localparam logic [3:0] LIM_MUL = 4'ha;
    localparam int ACC_LIM = 1 << 30;
    // Timing
    localparam int CLK_KHZ = 25000;
    localparam int SAMPLE_US = 1000;
    localparam int TI_UNIT_US = 100000;
    localparam int TD_UNIT_US = 10000;
    localparam int SAMPLE_CYC_DEF = SAMPLE_US * CLK_KHZ / 1000;
    localparam logic [15:0] TI_DIV = 16'(TI_UNIT_US / SAMPLE_US);
    localparam logic [15:0] TD_MUL = 16'(TD_UNIT_US / SAMPLE_US);
    // Types
    typedef enum logic [1:0] {SCH_PID, SCH_NORMAL, SCH_MULTI, SCH_JOG}
        psr_scheme_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAITP, ST_WAITI} psr_state_t;
endpackage : psr_pkg

// ### psr_div.sv
// Iterative unsigned divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module psr_div #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    // Result
    output logic busy,
    output logic [W-1:0] quot
);
    localparam int CW = $clog2(W + 1);
    logic [W:0] rem_q;
    logic [W-1:0] quo_q;
    logic [W-1:0] dvs_q;
    logic [CW-1:0] cnt_q;
    wire [W:0] shifted = {rem_q[W-1:0], quo_q[W-1]};
    wire fits = shifted >= {1'b0, dvs_q};

    // Restoring shift-subtract step
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rem_q <= '0;
            quo_q <= '0;
            dvs_q <= '0;
            cnt_q <= '0;
        end else if (start) begin
            rem_q <= '0;
            quo_q <= dividend;
            dvs_q <= divisor;
            cnt_q <= CW'(W);
        end else if (cnt_q != '0) begin
            rem_q <= fits ? shifted - {1'b0, dvs_q} : shifted;
            quo_q <= {quo_q[W-2:0], fits};
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = cnt_q != '0;
    assign quot = quo_q;
endmodule : psr_div
`default_nettype wire

// ### psr_proc_src.sv
// Model of the set point source and process detector
`timescale 1ns/10ps
`default_nettype none
module psr_proc_src (
    // Clock
    input wire logic mclk,
    // Wanted levels in 0.01 % units
    input wire logic [15:0] sp_lvl,
    input wire logic [15:0] pv_lvl,
    input wire logic [15:0] bias_lvl,
    // Analog samples
    output logic [15:0] ain1,
    output logic [15:0] ain2,
    output logic [15:0] ain4
);
    // One scale on both channels, so their 0 and 100 % points agree
    always_ff @(posedge mclk) begin
        ain1 <= bias_lvl;
        ain2 <= sp_lvl;
        ain4 <= pv_lvl;
    end
endmodule : psr_proc_src
`default_nettype wire

// ### test_psr_regulator.sv
// Self-checking bench for the PID speed regulator
`timescale 1ns/10ps
`default_nettype none
module test_psr_regulator
    import psr_pkg::*;
;
    localparam int SC = 100;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cancel = 1'b0, sel_h = 1'b0, sel_m = 1'b0, sel_l = 1'b0;
    logic jog = 1'b0, cie = 1'b0;
    logic [1:0] run_state = 2'h0;
    logic [15:0] sp = 16'h0000, pv = 16'h0000, bias = 16'h0000;
    logic [15:0] reg_rdata, speed, ain1, ain2, ain4;
    logic [1:0] scheme;
    logic a4_en, up, lo, fwd;
    int checks = 0;
    int n_mismatch = 0;
    int cyc = 0;

    // Clock
    always #20 mclk = ~mclk;

    psr_proc_src i_src (.mclk(mclk), .sp_lvl(sp), .pv_lvl(pv),
        .bias_lvl(bias), .ain1(ain1), .ain2(ain2), .ain4(ain4));

    psr_regulator #(.SAMPLE_CYC(SC)) i_dut (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ain1(ain1), .ain2(ain2),
        .ain4(ain4), .pid_cancel_input(cancel), .speed_select_high(sel_h),
        .speed_select_mid(sel_m), .speed_select_low(sel_l),
        .jog_input(jog), .current_input_enable(cie),
        .run_state(run_state), .speed_command(speed), .run_scheme(scheme),
        .ain4_enable(a4_en), .upper_limit_flag(up), .lower_limit_flag(lo),
        .forward_run_indicator(fwd));

    ////////////////////////////////////////////////////////////////////
    // Comparison, register access and waiting
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // Two full samples plus the computing time
    task automatic set_ain(input logic [15:0] s, p, b);
        @(posedge mclk);
        sp <= s;
        pv <= p;
        bias <= b;
        tick(2 * SC + 80);
    endtask : set_ain

    task automatic pid_case(input logic [15:0] m, s, p, b, band, exp);
        wr(ADR_MODE, m);
        wr(ADR_BAND, band);
        set_ain(s, p, b);
        chk("scheme", 16'(scheme), 16'h0000);
        chk("ain4_en", 16'(a4_en), 16'h0001);
        chk("speed", speed, exp);
    endtask : pid_case

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd(ADR_MODE, RST_MODE);
        rd(ADR_BAND, RST_BAND);
        rd(ADR_TI, RST_TI);
        rd(ADR_TD, RST_TD);
        rd(ADR_UPPER, RST_LIM);
        rd(ADR_LOWER, RST_LIM);
        rd(ADR_SETPT, RST_SETPT);
        rd(ADR_OPMODE, RST_OPM);
        wr(ADR_STATUS, 16'hffff);
        rd(ADR_STATUS, 16'h0000);
        wr(4'hc, 16'h1234);
        rd(4'hc, 16'h0000);
        // No PID: speed follows set point plus input 1
        set_ain(16'h0bb8, 16'h07d0, 16'h01f4);
        chk("scheme", 16'(scheme), 16'h0001);
        chk("speed", speed, 16'h0dac);
        chk("ain4_en", 16'(a4_en), 16'h0000);
        @(posedge mclk);
        cie <= 1'b1;
        tick(6);
        chk("ain4_en", 16'(a4_en), 16'h0001);
        @(posedge mclk);
        cie <= 1'b0;
        // Panel set point only in panel and combined modes
        wr(ADR_OPMODE, OPM_PANEL);
        wr(ADR_SETPT, 16'h07d0);
        tick(10);
        chk("panel sp", speed, 16'h09c4);
        wr(ADR_OPMODE, OPM_COMB_A);
        tick(10);
        chk("comb sp", speed, 16'h09c4);
        wr(ADR_OPMODE, OPM_COMB_B);
        tick(10);
        chk("comb sp", speed, 16'h09c4);
        wr(ADR_OPMODE, RST_OPM);
        tick(10);
        chk("ext sp", speed, 16'h0dac);
        // Proportional only, both input schemes and actions
        wr(ADR_TI, OFF_CODE);
        pid_case(MODE_SPV_REV, 16'h1388, 16'h0bb8, 16'h0, RST_BAND,
            16'h07d0);
        pid_case(MODE_SPV_REV, 16'h0bb8, 16'h1388, 16'h0, RST_BAND,
            16'h0000);
        pid_case(MODE_SPV_FWD, 16'h0bb8, 16'h1388, 16'h0, RST_BAND,
            16'h07d0);
        pid_case(MODE_SPV_FWD, 16'h1388, 16'h0bb8, 16'h0, RST_BAND,
            16'h0000);
        pid_case(MODE_SPV_REV, 16'h1194, 16'h0bb8, 16'h01f4, RST_BAND,
            16'h07d0);
        pid_case(MODE_SPV_REV, 16'h1388, 16'h0bb8, 16'h0, 16'h01f4,
            16'h0fa0);
        pid_case(MODE_DEV_REV, 16'h2328, 16'h0064, 16'h05dc, RST_BAND,
            16'h05dc);
        pid_case(MODE_DEV_FWD, 16'h2328, 16'h0064, 16'hfa24, RST_BAND,
            16'h05dc);
        // Derivative kick on a deviation step of -15.00 to -20.00 %
        wr(ADR_TD, 16'h0001);
        @(posedge mclk);
        bias <= 16'hf830;
        for (int i = 0; i < 3 * SC && speed === 16'h05dc; i++) begin
            tick(1);
        end
        chk("deriv", speed, 16'h1b58);
        wr(ADR_TD, OFF_CODE);
        // Process limits, 50.0 % upper and 30.0 % lower
        wr(ADR_MODE, MODE_SPV_REV);
        wr(ADR_UPPER, 16'h01f4);
        wr(ADR_LOWER, 16'h012c);
        set_ain(16'h1388, 16'h1770, 16'h0);
        chk("upper", 16'(up), 16'h0001);
        chk("lower", 16'(lo), 16'h0000);
        rd(ADR_STATUS, 16'h0005);
        set_ain(16'h1388, 16'h1388, 16'h0);
        chk("upper", 16'(up), 16'h0000);
        set_ain(16'h1388, 16'h07d0, 16'h0);
        chk("lower", 16'(lo), 16'h0001);
        wr(ADR_LOWER, OFF_CODE);
        tick(10);
        chk("lower", 16'(lo), 16'h0000);
        // Schemes that suspend or forbid PID
        @(posedge mclk);
        cancel <= 1'b1;
        tick(6);
        chk("scheme", 16'(scheme), 16'h0001);
        @(posedge mclk);
        cancel <= 1'b0;
        sel_h <= 1'b1;
        tick(6);
        chk("scheme", 16'(scheme), 16'h0002);
        @(posedge mclk);
        sel_h <= 1'b0;
        sel_m <= 1'b1;
        tick(6);
        chk("scheme", 16'(scheme), 16'h0002);
        @(posedge mclk);
        sel_m <= 1'b0;
        sel_l <= 1'b1;
        tick(6);
        chk("scheme", 16'(scheme), 16'h0002);
        @(posedge mclk);
        jog <= 1'b1;
        tick(6);
        chk("scheme", 16'(scheme), 16'h0003);
        @(posedge mclk);
        jog <= 1'b0;
        sel_l <= 1'b0;
        wr(ADR_OPMODE, OPM_SWITCH);
        tick(6);
        chk("scheme", 16'(scheme), 16'h0001);
        wr(ADR_OPMODE, RST_OPM);
        // Forward indicator
        run_state <= RUN_FWD;
        tick(6);
        chk("fwd", 16'(fwd), 16'h0001);
        @(posedge mclk);
        run_state <= 2'h2;
        tick(6);
        chk("fwd", 16'(fwd), 16'h0000);
        // Integral grows, then clears while cancelled
        wr(ADR_TI, RST_TI);
        set_ain(16'h1388, 16'h0bb8, 16'h0);
        tick(10 * SC);
        chk("integral", 16'(speed > 16'h07d0), 16'h0001);
        @(posedge mclk);
        cancel <= 1'b1;
        tick(10);
        chk("normal", speed, 16'h1388);
        @(posedge mclk);
        cancel <= 1'b0;
        for (int i = 0; i < 3 * SC && speed === 16'h1388; i++) begin
            tick(1);
        end
        chk("restart", speed, 16'h07d2);
        summarize();
    end
endmodule : test_psr_regulator
`default_nettype wire
